// ---- rtl/mcy_pkg.sv ----
// What this block does
// - three cycles from acquisition to output
// - 4 kHz rate gives 250 us cycle
// - latency at 4 kHz is 750 us
// - stages overlap, one value per cycle
// - six rates from 250 Hz to 8 kHz
// - one exposure per measurement cycle
// - reset selects 2 kHz rate
// - laser setting acts only when control grounded
// - multifunction input: trigger, zero, teach, inactive
// - zeroing input loads master value
// - teaching input raises a one-clock teach pulse
// - key assignable; inactive locks key
// - measurement task loads parameter preset
// - only rate has a saved copy, reloaded by restore strobe; reset loads defaults into both
// - configuration arrives as host commands
// - triggered output starts three to four cycles later
`default_nettype none
package mcy_pkg;
    localparam int unsigned CLK_HZ          = 100_000_000;
    localparam int unsigned PIPE_DEPTH      = 3;
    localparam int unsigned VAL_W           = 16;
    localparam int unsigned RATE_250_HZ     = 250;
    localparam int unsigned RATE_500_HZ     = 500;
    localparam int unsigned RATE_1K_HZ      = 1000;
    localparam int unsigned RATE_2K_HZ      = 2000;
    localparam int unsigned RATE_4K_HZ      = 4000;
    localparam int unsigned RATE_8K_HZ      = 8000;
    // cycles per measurement cycle for each rate
    localparam int unsigned CYC_250 = CLK_HZ / RATE_250_HZ;
    localparam int unsigned CYC_500 = CLK_HZ / RATE_500_HZ;
    localparam int unsigned CYC_1K  = CLK_HZ / RATE_1K_HZ;
    localparam int unsigned CYC_2K  = CLK_HZ / RATE_2K_HZ;
    localparam int unsigned CYC_4K  = CLK_HZ / RATE_4K_HZ;
    localparam int unsigned CYC_8K  = CLK_HZ / RATE_8K_HZ;
    localparam int unsigned CNT_W   = 19;

    typedef enum logic [2:0] {
        RATE_250 = 3'h0, RATE_500 = 3'h1, RATE_1K = 3'h2,
        RATE_2K  = 3'h3, RATE_4K  = 3'h4, RATE_8K = 3'h5
    } mcy_rate_type;
    localparam mcy_rate_type RATE_RESET = RATE_2K;

    typedef enum logic [2:0] {
        MF_INACTIVE = 3'h0, MF_TRIG_HI = 3'h1, MF_TRIG_LO = 3'h2,
        MF_ZERO = 3'h3, MF_TEACH = 3'h4
    } mcy_mfi_type;

    typedef enum logic [1:0] {
        KEY_INACTIVE = 2'h0, KEY_ZERO = 2'h1, KEY_TEACH = 2'h2
    } mcy_key_type;

    typedef enum logic [1:0] {
        TASK_STANDARD = 2'h0, TASK_CHANGING = 2'h1, TASK_PENETRATE = 2'h2
    } mcy_task_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001, ST_RUN = 3'b010, ST_DRAIN = 3'b100
    } mcy_state_type;

    // preset word per task: peak mode, smoothing, threshold
    localparam logic [7:0] PRESET_STANDARD  = 8'h11;
    localparam logic [7:0] PRESET_CHANGING  = 8'h25;
    localparam logic [7:0] PRESET_PENETRATE = 8'h3A;
endpackage
`default_nettype wire

// ---- rtl/mcy_engine.sv ----
`default_nettype none
module mcy_engine
    import mcy_pkg::*;
(
    input  wire logic               sys_clk,
    input  wire logic               rst_n,
    // configuration from the command decoder
    input  wire logic               cfg_we,
    input  wire mcy_rate_type       cfg_rate,
    input  wire mcy_mfi_type        cfg_mfi,
    input  wire mcy_key_type        cfg_key,
    input  wire mcy_task_type       cfg_task,
    input  wire logic               cfg_laser_on,
    input  wire logic [VAL_W-1:0]   cfg_master,
    input  wire logic               cfg_save,
    input  wire logic               cfg_restore,
    // pins and acquisition
    input  wire logic               laser_ctl_gnd,
    input  wire logic               mfi_in,
    input  wire logic               key_in,
    input  wire logic [VAL_W-1:0]   acq_value,
    // outputs
    output logic                    expose,
    output logic                    laser_en,
    output logic [VAL_W-1:0]        out_value,
    output logic                    out_valid,
    output logic                    teach_pulse,
    output logic [7:0]              task_preset,
    output mcy_rate_type            rate_now
);
    mcy_rate_type        rate_r, rate_nxt, sv_rate_r, sv_rate_nxt;
    mcy_mfi_type         mfi_r, mfi_nxt;
    mcy_key_type         key_r, key_nxt;
    mcy_task_type        task_r, task_nxt;
    logic                laser_r, laser_nxt;
    logic [VAL_W-1:0]    master_r, master_nxt;
    logic [7:0]          preset_r, preset_nxt;
    logic [CNT_W-1:0]    cnt_r, cnt_nxt, period;
    logic                tick;
    logic [VAL_W-1:0]    stg_r [PIPE_DEPTH];
    logic [VAL_W-1:0]    stg_nxt [PIPE_DEPTH];
    logic [PIPE_DEPTH-1:0] vld_r, vld_nxt;
    logic                mfi_q_r, key_q_r, zero_r, zero_nxt;
    logic                expose_r, expose_nxt, teach_r, teach_nxt;
    logic                out_v_r, out_v_nxt;
    logic [VAL_W-1:0]    out_r, out_nxt;
    mcy_state_type       st_r, st_nxt;
    logic                trig_mode, trig_act, mfi_rise, key_rise;

    // cycle length from selected rate
    always_comb
    begin
        case (rate_r)
            RATE_250: period = CNT_W'(CYC_250);
            RATE_500: period = CNT_W'(CYC_500);
            RATE_1K:  period = CNT_W'(CYC_1K);
            RATE_2K:  period = CNT_W'(CYC_2K);
            RATE_4K:  period = CNT_W'(CYC_4K);
            RATE_8K:  period = CNT_W'(CYC_8K);
            default:  period = CNT_W'(CYC_2K);
        endcase
    end
    // cycle end; compare with >= so a shorter new period never overruns the count
    assign tick      = (cnt_r >= period - CNT_W'(1));
    assign trig_mode = (mfi_r == MF_TRIG_HI) || (mfi_r == MF_TRIG_LO);
    assign trig_act  = (mfi_r == MF_TRIG_HI) ? mfi_in : !mfi_in;
    assign mfi_rise  = mfi_in && !mfi_q_r;
    assign key_rise  = key_in && !key_q_r;

    // configuration: volatile working set and saved copy
    always_comb
    begin
        rate_nxt   = rate_r;
        sv_rate_nxt = sv_rate_r;
        mfi_nxt    = mfi_r;
        key_nxt    = key_r;
        task_nxt   = task_r;
        laser_nxt  = laser_r;
        master_nxt = master_r;
        if (cfg_we)
        begin
            rate_nxt   = cfg_rate;
            mfi_nxt    = cfg_mfi;
            key_nxt    = cfg_key;
            task_nxt   = cfg_task;
            laser_nxt  = cfg_laser_on;
            master_nxt = cfg_master;
        end
        if (cfg_save)
            sv_rate_nxt = rate_r;
        if (cfg_restore)
            rate_nxt = sv_rate_r;
        case (task_r)
            TASK_STANDARD:  preset_nxt = PRESET_STANDARD;
            TASK_CHANGING:  preset_nxt = PRESET_CHANGING;
            TASK_PENETRATE: preset_nxt = PRESET_PENETRATE;
            default:        preset_nxt = PRESET_STANDARD;
        endcase
    end

    // cycle timer, trigger state and inputs
    always_comb
    begin
        cnt_nxt    = tick ? '0 : cnt_r + CNT_W'(1);
        expose_nxt = tick;
        st_nxt     = st_r;
        case (st_r)
            ST_IDLE:  if (!trig_mode || trig_act) st_nxt = ST_RUN;
            ST_RUN:   if (trig_mode && !trig_act && tick) st_nxt = ST_DRAIN;
            ST_DRAIN: if (trig_act || !trig_mode) st_nxt = ST_RUN;
                      else if (tick && vld_r == '0) st_nxt = ST_IDLE;
            default:  st_nxt = ST_IDLE;
        endcase
        zero_nxt  = zero_r;
        teach_nxt = 1'b0;
        // request used up when it replaced a stage-2 value; a new request wins
        if (tick && vld_r[1])
            zero_nxt = 1'b0;
        if ((mfi_r == MF_ZERO && mfi_rise) || (key_r == KEY_ZERO && key_rise))
            zero_nxt = 1'b1;
        if ((mfi_r == MF_TEACH && mfi_rise) || (key_r == KEY_TEACH && key_rise))
            teach_nxt = 1'b1;
    end

    // three-stage pipeline, one shift per cycle
    always_comb
    begin
        for (int i = 0; i < PIPE_DEPTH; i++)
            stg_nxt[i] = stg_r[i];
        vld_nxt   = vld_r;
        out_nxt   = out_r;
        out_v_nxt = 1'b0;
        if (tick)
        begin
            stg_nxt[0] = acq_value;
            vld_nxt[0] = (st_r == ST_RUN);
            for (int i = 1; i < PIPE_DEPTH; i++)
            begin
                stg_nxt[i] = stg_r[i-1];
                vld_nxt[i] = vld_r[i-1];
            end
            if (zero_r && vld_r[1])
                stg_nxt[2] = master_r;
            if (vld_r[PIPE_DEPTH-1])
            begin
                out_nxt   = stg_r[PIPE_DEPTH-1];
                out_v_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            rate_r   <= RATE_RESET;
            sv_rate_r <= RATE_RESET;
            mfi_r    <= MF_INACTIVE;
            key_r    <= KEY_ZERO;
            task_r   <= TASK_STANDARD;
            laser_r  <= 1'b1;
            master_r <= '0;
            preset_r <= PRESET_STANDARD;
            cnt_r    <= '0;
            expose_r <= 1'b0;
            st_r     <= ST_IDLE;
            zero_r   <= 1'b0;
            teach_r  <= 1'b0;
            mfi_q_r  <= 1'b0;
            key_q_r  <= 1'b0;
            vld_r    <= '0;
            out_r    <= '0;
            out_v_r  <= 1'b0;
            for (int i = 0; i < PIPE_DEPTH; i++)
                stg_r[i] <= '0;
        end
        else
        begin
            rate_r   <= rate_nxt;
            sv_rate_r <= sv_rate_nxt;
            mfi_r    <= mfi_nxt;
            key_r    <= key_nxt;
            task_r   <= task_nxt;
            laser_r  <= laser_nxt;
            master_r <= master_nxt;
            preset_r <= preset_nxt;
            cnt_r    <= cnt_nxt;
            expose_r <= expose_nxt;
            st_r     <= st_nxt;
            zero_r   <= zero_nxt;
            teach_r  <= teach_nxt;
            mfi_q_r  <= mfi_in;
            key_q_r  <= key_in;
            vld_r    <= vld_nxt;
            out_r    <= out_nxt;
            out_v_r  <= out_v_nxt;
            for (int i = 0; i < PIPE_DEPTH; i++)
                stg_r[i] <= stg_nxt[i];
        end
    end

    // laser gate, registered
    logic las_r;
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            las_r <= 1'b1;
        else
            las_r <= laser_ctl_gnd ? laser_r : 1'b1;
    end

    assign expose      = expose_r;
    assign laser_en    = las_r;
    assign out_value   = out_r;
    assign out_valid   = out_v_r;
    assign teach_pulse = teach_r;
    assign task_preset = preset_r;
    assign rate_now    = rate_r;

    // checks
    chk_period_rate: assert property (@(posedge sys_clk) disable iff (!rst_n)
        rate_r == RATE_4K |-> period == CNT_W'(25000))
        else $error("period wrong at 4 kHz");
    chk_reset_rate: assert property (@(posedge sys_clk)
        $rose(rst_n) |-> rate_r == RATE_2K)
        else $error("reset rate not 2 kHz");
    chk_one_expose: assert property (@(posedge sys_clk) disable iff (!rst_n)
        expose_r |=> !expose_r)
        else $error("expose longer than one cycle");
    chk_pipe_shift: assert property (@(posedge sys_clk) disable iff (!rst_n)
        tick && vld_r[2] |=> out_v_r && out_r == $past(stg_r[2]))
        else $error("output not from third stage");
    chk_latency_track: assert property (@(posedge sys_clk) disable iff (!rst_n)
        tick && !trig_mode && st_r == ST_RUN |=> vld_r[0])
        else $error("stage not loaded");
    chk_laser_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !laser_ctl_gnd |=> las_r)
        else $error("laser off without ground");
    chk_zero_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
        tick && zero_r && vld_r[1] |=> stg_r[2] == $past(master_r))
        else $error("master not loaded");
    chk_key_lock: assert property (@(posedge sys_clk) disable iff (!rst_n)
        key_r == KEY_INACTIVE && mfi_r != MF_TEACH |=> !teach_r)
        else $error("locked key acted");
    chk_teach: assert property (@(posedge sys_clk) disable iff (!rst_n)
        mfi_r == MF_TEACH && mfi_rise |=> teach_r)
        else $error("teach missing");
    chk_preset: assert property (@(posedge sys_clk) disable iff (!rst_n)
        task_r == TASK_PENETRATE |=> preset_r == PRESET_PENETRATE)
        else $error("preset wrong");
    cov_output: cover property (@(posedge sys_clk) out_v_r);
    cov_zero: cover property (@(posedge sys_clk) zero_r && tick);
    cov_drain: cover property (@(posedge sys_clk) st_r == ST_DRAIN);
endmodule // mcy_engine
`default_nettype wire

// ---- bench/mcy_host.sv ----
`default_nettype none
// configuration source standing in for the serial command decoder
module mcy_host
    import mcy_pkg::*;
(
    input  wire logic            sys_clk,
    output var logic             cfg_we,
    output var mcy_rate_type     cfg_rate,
    output var mcy_mfi_type      cfg_mfi,
    output var mcy_key_type      cfg_key,
    output var mcy_task_type     cfg_task,
    output var logic             cfg_laser_on,
    output var logic [VAL_W-1:0] cfg_master,
    output var logic             cfg_save,
    output var logic             cfg_restore
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle values from time zero
    initial
    begin
        cfg_we = 1'b0;
        cfg_save = 1'b0;
        cfg_restore = 1'b0;
        cfg_laser_on = 1'b1;
        cfg_rate = RATE_2K;
        cfg_mfi = MF_INACTIVE;
        cfg_key = KEY_INACTIVE;
        cfg_task = TASK_STANDARD;
        cfg_master = 16'h0000;
    end
    // one whole configuration word, loaded on a single edge
    task automatic send(input mcy_rate_type r, input mcy_mfi_type m, input mcy_key_type k,
                        input mcy_task_type t, input logic l, input logic [VAL_W-1:0] v);
        @(posedge sys_clk);
        cfg_rate <= r;
        cfg_mfi <= m;
        cfg_key <= k;
        cfg_task <= t;
        cfg_laser_on <= l;
        cfg_master <= v;
        cfg_we <= 1'b1;
        @(posedge sys_clk);
        cfg_we <= 1'b0;
    endtask
    // one-clock save or restore strobe
    task automatic strobe(input logic restore);
        @(posedge sys_clk);
        cfg_save <= !restore;
        cfg_restore <= restore;
        @(posedge sys_clk);
        cfg_save <= 1'b0;
        cfg_restore <= 1'b0;
    endtask
endmodule // mcy_host
`default_nettype wire

// ---- bench/tb.sv ----
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import mcy_pkg::*;
    logic sys_clk = 1'b0, rst_n = 1'b0, laser_ctl_gnd = 1'b0, mfi_in = 1'b0, key_in = 1'b0;
    logic [VAL_W-1:0] acq_value = 16'h1111, out_value, last_val;
    logic cfg_we, cfg_laser_on, cfg_save, cfg_restore, expose, laser_en, out_valid, teach_pulse;
    logic [VAL_W-1:0] cfg_master;
    logic [7:0] task_preset;
    mcy_rate_type cfg_rate, rate_now;
    mcy_mfi_type cfg_mfi;
    mcy_key_type cfg_key;
    mcy_task_type cfg_task;
    int unsigned t_clk = 0, n_val = 0, n_exp = 0, n_teach = 0, exp_gap, val_gap, t_exp, t_val;
    int unsigned num_errors = 0, compares = 0, t0, t1, base, vbase;
    logic seen;
    logic [7:0] presets [3] = '{PRESET_STANDARD, PRESET_CHANGING, PRESET_PENETRATE};
    mcy_engine dut (.*);
    mcy_host host (.*);
    // 100 MHz clock
    always #5 sys_clk = ~sys_clk;
    // event monitors: counts and spacings of the output pulses
    always @(posedge sys_clk)
    begin
        t_clk <= t_clk + 1;
        if (expose === 1'b1)
        begin
            n_exp <= n_exp + 1;
            exp_gap <= t_clk - t_exp;
            t_exp <= t_clk;
        end
        if (out_valid === 1'b1)
        begin
            n_val <= n_val + 1;
            val_gap <= t_clk - t_val;
            t_val <= t_clk;
            last_val <= out_value;
        end
        if (teach_pulse === 1'b1)
            n_teach <= n_teach + 1;
    end
    task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // drive one input high for three clocks, then low
    task automatic press(input logic use_key);
        @(posedge sys_clk);
        if (use_key) key_in <= 1'b1; else mfi_in <= 1'b1;
        repeat (3) @(posedge sys_clk);
        key_in <= 1'b0;
        mfi_in <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask
    // wait for the next output pulse, bounded by five measurement cycles
    task automatic next_val();
        int unsigned n;
        n = n_val;
        for (int i = 0; i < 5 * CYC_8K && n_val == n; i++) @(posedge sys_clk);
        check("out_valid arrival", n_val != n, 1);
    endtask
    // hang guard, past the six measurement cycles at 8 kHz the run needs
    initial
    begin
        #1ms;
        num_errors++;
        summarize();
    end
    // main sequence
    initial
    begin
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        check("rate_now", rate_now, RATE_2K);
        check("laser_en", laser_en, 1);
        laser_ctl_gnd <= 1'b1;
        host.send(RATE_8K, MF_TEACH, KEY_INACTIVE, TASK_STANDARD, 1'b0, 16'h0000);
        repeat (3) @(posedge sys_clk);
        check("laser_en off", laser_en, 0);
        laser_ctl_gnd <= 1'b0;
        repeat (3) @(posedge sys_clk);
        check("laser_en ungrounded", laser_en, 1);
        for (int i = 2; i >= 0; i--)
        begin
            host.send(RATE_8K, MF_TEACH, KEY_INACTIVE, mcy_task_type'(i), 1'b1, 16'h0000);
            repeat (2) @(posedge sys_clk);
            check("task_preset", task_preset, presets[i]);
        end
        host.strobe(1'b0);
        host.send(RATE_250, MF_TEACH, KEY_INACTIVE, TASK_STANDARD, 1'b1, 16'h0000);
        host.strobe(1'b1);
        repeat (2) @(posedge sys_clk);
        check("rate_now restored", rate_now, RATE_8K);
        base = n_teach;
        press(1'b1);
        check("teach count locked key", n_teach, base);
        press(1'b0);
        check("teach count input", n_teach, base + 1);
        host.send(RATE_8K, MF_ZERO, KEY_TEACH, TASK_STANDARD, 1'b1, 16'hA5C3);
        press(1'b1);
        check("teach count key", n_teach, base + 2);
        // high level trigger raised before the first cycle end, new sample value
        host.send(RATE_8K, MF_TRIG_HI, KEY_TEACH, TASK_STANDARD, 1'b1, 16'hA5C3);
        mfi_in <= 1'b1;
        acq_value <= 16'h5E7A;
        t1 = t_clk;
        @(posedge sys_clk iff expose === 1'b1);
        t0 = t_clk;
        for (int i = 0; i < 5 && last_val !== 16'h5E7A; i++) next_val();
        check("acquire to output", t_val - t0, 3 * CYC_8K);
        check("trigger to output", (t_val - t1 >= 3 * CYC_8K) && (t_val - t1 <= 4 * CYC_8K), 1);
        // back to zeroing; input low first so the press is a fresh edge
        mfi_in <= 1'b0;
        host.send(RATE_8K, MF_ZERO, KEY_TEACH, TASK_STANDARD, 1'b1, 16'hA5C3);
        press(1'b0);
        base = n_exp;
        vbase = n_val;
        seen = 1'b0;
        for (int i = 0; i < 5 && !seen; i++)
        begin
            next_val();
            seen = (last_val === 16'hA5C3);
        end
        check("master value seen", seen, 1);
        check("expose spacing", exp_gap, CYC_8K);
        check("output spacing", val_gap, CYC_8K);
        check("one expose per value", n_exp - base, n_val - vbase);
        summarize();
    end
endmodule // tb
`default_nettype wire
